// *** fcd_divider.sv ***
// Flash clock divider with control register and timed-operation gate.
// Assumes bus-rate clock, plain register port, and a sequencer that asks for n ticks.
`timescale 1ns/1ps
module fcd_divider (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sequencer request
  input wire logic op_start,
  input wire logic [15:0] op_pulses,
  output logic op_accept,
  output logic op_refused,
  output logic op_busy,
  output logic op_done,
  // Flash timing
  output logic flash_timing_clock,
  output logic flash_tick,
  output logic program_enable
);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic prescale_by_eight_r;
  logic [5:0] clock_divisor_field_r;
  logic divisor_loaded_flag_r;
  logic [7:0] reg_rdata_r;
  logic op_busy_r;
  logic op_done_r;

  wire ctrl_wr = reg_wr && (reg_addr == fcd_pkg::FCD_ADDR_CTRL);
  wire [7:0] ctrl_val = {divisor_loaded_flag_r, prescale_by_eight_r, clock_divisor_field_r};
  wire [7:0] status_val = {5'h00, op_done_r, op_busy_r, divisor_loaded_flag_r};
  wire [7:0] rd_mux = (reg_addr == fcd_pkg::FCD_ADDR_CTRL) ? ctrl_val :
                      (reg_addr == fcd_pkg::FCD_ADDR_STATUS) ? status_val : 8'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prescale_by_eight_r <= fcd_pkg::FCD_RST_PRESCALE;
      clock_divisor_field_r <= fcd_pkg::FCD_RST_DIV;
      divisor_loaded_flag_r <= fcd_pkg::FCD_RST_LOADED;
    end else if (ctrl_wr) begin
      prescale_by_eight_r <= reg_wdata[fcd_pkg::FCD_PRESCALE_BIT];
      clock_divisor_field_r <= reg_wdata[fcd_pkg::FCD_DIV_MSB:0];
      divisor_loaded_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // ----------------------------------------
  // Prescaler and divisor
  // ----------------------------------------
  // A new setting restarts both stages so no short pulse follows.
  logic pre_wrap;
  logic div_wrap;
  wire div_step = prescale_by_eight_r ? pre_wrap : 1'b1;

  fcd_counter #(.W(3)) u_pre (
    .clock(clock),
    .sys_rst(sys_rst),
    .step(1'b1),
    .restart(ctrl_wr),
    .last(fcd_pkg::FCD_PRESCALE_LAST),
    .wrap(pre_wrap)
  );

  fcd_counter #(.W(fcd_pkg::FCD_DIV_W)) u_div (
    .clock(clock),
    .sys_rst(sys_rst),
    .step(div_step && !ctrl_wr),
    .restart(ctrl_wr),
    .last(clock_divisor_field_r),
    .wrap(div_wrap)
  );

  // ----------------------------------------
  // Flash clock output
  // ----------------------------------------
  // One bus cycle tick per flash period; the level output toggles on each tick.
  logic tick_r;
  logic fclk_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_r <= 1'b0;
      fclk_r <= 1'b0;
    end else begin
      tick_r <= div_wrap;
      fclk_r <= div_wrap ? !fclk_r : fclk_r;
    end
  end
  assign flash_tick = tick_r;
  assign flash_timing_clock = fclk_r;
  assign program_enable = divisor_loaded_flag_r;

  // ----------------------------------------
  // Operation timer
  // ----------------------------------------
  fcd_pkg::fcd_state_e state_r;
  fcd_pkg::fcd_state_e state_nxt;
  logic [15:0] left_r;
  logic [15:0] left_nxt;

  wire start_ok = op_start && divisor_loaded_flag_r && (op_pulses != 16'h0000);
  assign op_accept = (state_r == fcd_pkg::FCD_IDLE) && start_ok;
  assign op_refused = op_start && !op_accept;

  always_comb begin
    state_nxt = state_r;
    left_nxt = left_r;
    unique case (state_r)
      fcd_pkg::FCD_IDLE: begin
        if (start_ok) begin
          state_nxt = fcd_pkg::FCD_RUN;
          left_nxt = op_pulses;
        end
      end
      fcd_pkg::FCD_RUN: begin
        if (tick_r) begin
          left_nxt = left_r - 16'h0001;
          if (left_r == 16'h0001) begin
            state_nxt = fcd_pkg::FCD_DONE;
          end
        end
      end
      fcd_pkg::FCD_DONE: begin
        state_nxt = fcd_pkg::FCD_IDLE;
      end
      default: begin
        state_nxt = fcd_pkg::FCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= fcd_pkg::FCD_IDLE;
      left_r <= 16'h0000;
      op_busy_r <= 1'b0;
      op_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      left_r <= left_nxt;
      op_busy_r <= (state_nxt == fcd_pkg::FCD_RUN);
      op_done_r <= (state_nxt == fcd_pkg::FCD_DONE);
    end
  end
  assign op_busy = op_busy_r;
  assign op_done = op_done_r;

endmodule // fcd_divider

// *** fcd_pkg.sv ***
// Package for the flash clock divider: register layout, reset values, divider constants.
// Assumes a single bus-rate clock domain and a two-register space (control and status).
package fcd_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] FCD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] FCD_ADDR_STATUS = 4'h1;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int FCD_LOADED_BIT = 7;
  localparam int FCD_PRESCALE_BIT = 6;
  localparam int FCD_DIV_MSB = 5;
  localparam int FCD_DIV_W = 6;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic FCD_RST_PRESCALE = 1'b0;
  localparam logic [5:0] FCD_RST_DIV = 6'h00;
  localparam logic FCD_RST_LOADED = 1'b0;

  // ----------------------------------------
  // Divider constants
  // ----------------------------------------
  localparam logic [2:0] FCD_PRESCALE_LAST = 3'h7;
  localparam int FCD_CLK_MHZ = 100;

  // ----------------------------------------
  // Sequencer request states
  // ----------------------------------------
  typedef enum logic [2:0] {
    FCD_IDLE = 3'b001,
    FCD_RUN = 3'b010,
    FCD_DONE = 3'b100
  } fcd_state_e;

endpackage

// *** fcd_counter.sv ***
// Wrap counter used for the divide-by-8 prescaler and the divisor stage.
// Assumes synchronous active-high reset on the bus clock.
`timescale 1ns/1ps
module fcd_counter #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Count control
  input wire logic step,
  input wire logic restart,
  input wire logic [W-1:0] last,
  // Result
  output logic wrap
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire at_last = (cnt_r >= last);

  assign wrap = step && at_last;
  assign cnt_nxt = restart ? '0 : (!step ? cnt_r : (at_last ? '0 : cnt_r + 1'b1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // fcd_counter

// *** fcd_divider_assertions.sv ***
// Port checker for the flash clock divider.
// Assumes one bus clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fcd_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Operation and timing
  input wire logic op_start,
  input wire logic op_accept,
  input wire logic op_refused,
  input wire logic op_done,
  input wire logic flash_tick,
  input wire logic program_enable
);
  // ----------------------------------------
  // Shadow of the divider setting
  // ----------------------------------------
  logic [6:0] ctl_r;
  logic [9:0] cnt_r;
  logic arm_r;
  wire wr0 = reg_wr && reg_addr == fcd_pkg::FCD_ADDR_CTRL;
  wire [9:0] per = (ctl_r[6] ? 10'h008 : 10'h001) * ({4'h0, ctl_r[5:0]} + 10'h001);
  // Gap check armed only after a tick, since a write shifts the phase
  always_ff @(posedge clock) begin
    ctl_r <= sys_rst ? 7'h00 : (wr0 ? reg_wdata[6:0] : ctl_r);
    cnt_r <= (sys_rst || wr0 || flash_tick) ? 10'h000 : cnt_r + 10'h001;
    arm_r <= (sys_rst || wr0) ? 1'b0 : (flash_tick | arm_r);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  flag_on_write_a: assert property ($rose(program_enable) |-> $past(wr0)) else $error("flag set without write");
  flag_sticky_a: assert property (!$fell(program_enable)) else $error("flag cleared without reset");
  gate_closed_a: assert property (op_start && !program_enable |-> op_refused && !op_accept)
    else $error("operation not blocked");
  prescale_gap_a: assert property (flash_tick && arm_r && ctl_r[6] |-> cnt_r == per - 10'h001)
    else $error("prescaled tick gap wrong");
  direct_gap_a: assert property (flash_tick && arm_r && !ctl_r[6] |-> cnt_r == per - 10'h001)
    else $error("tick gap wrong");
  one_pulse_a: assert property (flash_tick && arm_r && per > 10'h001 |=> !flash_tick) else $error("pulse too long");
  whole_pulse_a: assert property ($rose(op_done) |-> $past(flash_tick)) else $error("done off a pulse");
  undivided_a: assert property (!program_enable && !reg_wr && $past(flash_tick) |-> flash_tick)
    else $error("reset divider not passing clock");
  cover property (wr0 && program_enable);
  cover property (op_accept);
  cover property (op_done);
endmodule // fcd_checker
bind fcd_divider fcd_checker u_fcd_checker (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .op_start(op_start), .op_accept(op_accept), .op_refused(op_refused),
  .op_done(op_done), .flash_tick(flash_tick), .program_enable(program_enable));

// *** flash_clock_divider_tb.sv ***
// Self-checking bench for the flash clock divider.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module flash_clock_divider_tb;
  // ----------------------------------------
  // Signals, tasks and stimulus
  // ----------------------------------------
  logic clock, sys_rst, reg_wr, reg_rd, op_start, op_accept, op_refused, op_busy, op_done, flash_tick, program_enable;
  logic flash_timing_clock;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, v;
  logic [15:0] op_pulses;
  int mismatches, comparisons, seed, n, k, i;
  fcd_divider u_fcd_divider (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start), .op_pulses(op_pulses),
    .op_accept(op_accept), .op_refused(op_refused), .op_busy(op_busy), .op_done(op_done),
    .flash_timing_clock(flash_timing_clock), .flash_tick(flash_tick), .program_enable(program_enable));
  task automatic chk(string w, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] x);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= x; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Cycles between two ticks; a timeout counts a mismatch and ends the run
  task automatic gap();
    int t0;
    logic f0;
    t0 = -1; n = -1; f0 = 1'b0;
    for (k = 0; k < 2000 && n < 0; k++) begin
      @(posedge clock);
      #1 if (flash_tick) begin
        if (t0 >= 0) begin
          n = k - t0;
          chk("flash clock", !f0, flash_timing_clock);
        end
        t0 = k;
        f0 = flash_timing_clock;
      end
    end
    if (n < 0) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    seed = 39; sys_rst = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    op_start = 1'b0; op_pulses = 16'h0000;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    gap(); chk("reset gap", 1, n);
    wr(4'h5, 8'h7f); rd(4'h5); chk("unmapped", 0, d);
    rd(fcd_pkg::FCD_ADDR_CTRL); chk("control", 0, d);
    chk("flag", 0, program_enable);
    @(posedge clock);
    op_start <= 1'b1; op_pulses <= 16'h0001;
    #1 chk("refused", 1, op_refused);
    for (i = 0; i < 7; i++) begin
      @(posedge clock);
      op_start <= 1'b0;
      v = 8'($random(seed)); v[5:3] = 3'h0; v[6] = i[0];
      if (i == 6) v = 8'h7e;
      wr(fcd_pkg::FCD_ADDR_CTRL, v);
      rd(fcd_pkg::FCD_ADDR_CTRL); chk("control", {8'h00, 1'b1, v[6:0]}, d);
      chk("flag", 1, program_enable);
      gap(); chk("tick gap", (v[6] ? 8 : 1) * (v[5:0] + 1), n);
      @(posedge clock);
      op_start <= 1'b1; op_pulses <= 16'(($random(seed) & 3) + 1);
      #1 chk("accept", 1, op_accept);
      n = 0;
      @(posedge clock);
      op_start <= 1'b0;
      // Sample settled values each cycle, starting the cycle after the accept cycle
      for (k = 0; k < 3000; k++) begin
        #1 if (op_done === 1'b1) break;
        if (flash_tick && op_busy) n++;
        @(posedge clock);
      end
      if (k == 3000) begin
        mismatches++;
        end_of_test();
      end
      chk("pulses", op_pulses, n);
      rd(fcd_pkg::FCD_ADDR_STATUS); chk("status", 1, d);
    end
    end_of_test();
  end
endmodule // flash_clock_divider_tb
